// file: design/pps_pkg.sv
package pps_pkg;
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned TICK_US      = 1000;
  localparam int unsigned TICK_CYCLES  = (CLK_HZ / 1_000_000) * TICK_US;
  localparam logic [31:0] RESP_OKAY    = 32'h0000_0000;
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_STATUS    = 8'h04;
  localparam logic [7:0] OFF_MODE      = 8'h08;
  localparam logic [7:0] OFF_OPTION    = 8'h0C;
  localparam logic [7:0] OFF_PROFILE   = 8'h10;
  localparam logic [7:0] OFF_TARGET    = 8'h14;
  localparam logic [7:0] OFF_LIM_MIN   = 8'h18;
  localparam logic [7:0] OFF_LIM_MAX   = 8'h1C;
  localparam logic [7:0] OFF_RANGE_MIN = 8'h20;
  localparam logic [7:0] OFF_RANGE_MAX = 8'h24;
  localparam logic [7:0] OFF_ACT_POS   = 8'h28;
  localparam logic [7:0] OFF_DEM_POS   = 8'h2C;
  localparam logic [7:0] OFF_POS_WIN   = 8'h30;
  localparam logic [7:0] OFF_WIN_TIME  = 8'h34;
  localparam logic [7:0] OFF_FE_WIN    = 8'h38;
  localparam logic [7:0] OFF_FE_TIME   = 8'h3C;
  localparam logic [7:0] OFF_TGT_VEL   = 8'h40;
  localparam logic [7:0] OFF_VEL_MIN   = 8'h44;
  localparam logic [7:0] OFF_VEL_MAX   = 8'h48;
  localparam logic [7:0] OFF_PROF_VEL  = 8'h4C;
  localparam logic [7:0] OFF_END_VEL   = 8'h50;
  localparam logic [7:0] OFF_ACCEL     = 8'h54;
  localparam logic [7:0] OFF_DECEL     = 8'h58;
  localparam logic [7:0] OFF_QS_DECEL  = 8'h5C;
  localparam logic [7:0] OFF_MAX_ACC   = 8'h60;
  localparam logic [7:0] OFF_MAX_DEC   = 8'h64;
  localparam logic [7:0] OFF_SEL_PAR   = 8'h68;
  localparam int CW_NEW_SP   = 4;
  localparam int CW_IMMED    = 5;
  localparam int CW_REL      = 6;
  localparam int CW_HALT     = 8;
  localparam int CW_CHG_SP   = 9;
  localparam int CW_QSTOP    = 2;
  localparam int CW_CLOSED   = 10;
  localparam int SW_REACHED  = 10;
  localparam int SW_LIMIT    = 11;
  localparam int SW_ACK      = 12;
  localparam int SW_FOLLOW   = 13;
  localparam int SW_BUF_FULL = 14;
  localparam int SW_JERK     = 15;
  localparam int SW_PASS     = 16;
  localparam int SW_QS_RAMP  = 17;
  localparam int SW_HALTED   = 18;
  localparam int OPT_CLR_LO  = 4;
  localparam int OPT_CLR_HI  = 5;
  localparam int OPT_REF_LO  = 0;
  localparam logic [7:0] MODE_POSITION = 8'h01;
  localparam logic [7:0] MODE_VELOCITY = 8'h02;
  localparam logic [7:0] PROFILE_JERK  = 8'h03;
  localparam logic [31:0] RESET_ZERO   = 32'h0000_0000;
  typedef struct packed {
    logic [31:0] target;
    logic [31:0] vel;
    logic [31:0] acc;
    logic [31:0] dec;
    logic        rel;
  } pps_cmd_t;
endpackage : pps_pkg

// file: design/pps_param_mem.sv
`timescale 1ns/1ps
// Parameter store for active and buffered travel commands
module pps_param_mem import pps_pkg::*; (
  input  wire logic     hclk,    // Clock
  input  wire logic     hresetn, // Reset, active low
  input  wire logic     wr_en,   // Write strobe
  input  wire logic     wr_addr, // Slot written; rd_addr slot is active, other is pending
  input  wire pps_cmd_t wr_data, // Command written
  input  wire logic     rd_addr, // Read select
  output pps_cmd_t      rd_data  // Registered read
);
  pps_cmd_t mem [2];

  // Cleared so command fields never read as unknown
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem[0] <= '0;
      mem[1] <= '0;
    end else if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_data <= '0;
    end else if (wr_en && wr_addr == rd_addr) begin
      rd_data <= wr_data;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : pps_param_mem

// file: design/pps_setpoint_ctrl.sv
// Implementation choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
// Function
// - Target reached after settle window time
// - Position limit bit when demand outside limits
// - Acknowledge follows new-set-point bit
// - Queued move: ack held until buffer frees
// - Commands while ack set are dropped
// - No ack for unreachable target
// - No ack while move and pending, unless immediate bit set
// - Following error after window timeout
// - Rising bit four starts valid move
// - Option code bits self-clear new set-point
// - Ack low while buffer has room
// - One buffered command with own parameters
// - Immediate bit bypasses the buffer
// - Bit nine passes through at speed
// - Relative base from post-arrival sample
// - Profile type three only sets the jerk status bit
// - Ramps capped at maximum acc/dec, except quick stop
// - Quick stop uses quick stop deceleration
// - Positions wrap within range limits
// - Speed capped, arrive with end velocity
// - Mode two runs plain velocity mode
// - Halt bit ramps down and up
// - Velocity limit bit outside speed limits
// - Bit six relative, option selects reference
// - Set-point and motion processing on 1 ms tick
module pps_setpoint_ctrl import pps_pkg::*; #(
  parameter int unsigned TICK_LEN = TICK_CYCLES // Cycles per control tick
) (
  input  wire logic        hclk,      // Clock
  input  wire logic        hresetn,   // Reset, active low
  input  wire logic        hsel,      // Slave select
  input  wire logic [31:0] haddr,     // Address
  input  wire logic [1:0]  htrans,    // Transfer type
  input  wire logic        hwrite,    // Write
  input  wire logic [2:0]  hsize,     // Size
  input  wire logic        hready,    // Bus ready
  input  wire logic [31:0] hwdata,    // Write data
  output logic [31:0]      hrdata,    // Read data
  output logic             hreadyout, // Slave ready
  output logic             hresp,     // Response
  output logic             tick,      // Control tick pulse
  output logic [31:0]      demand     // Demand position
);
  typedef enum logic [1:0] {PPS_IDLE, PPS_MOVE, PPS_SETTLE} pps_state_t;
  logic [7:0]  a_addr;
  logic        a_wr, a_rd;
  logic [31:0] ctrl, status_w, mode, option, profile, target;
  logic [31:0] lim_min, lim_max, rng_min, rng_max, act_pos, pos_win;
  logic [31:0] win_time, fe_win, fe_time, tgt_vel, vel_min, vel_max;
  logic [31:0] prof_vel, end_vel, acc, dec, qs_dec, max_acc, max_dec;
  logic [31:0] tick_cnt, win_cnt, fe_cnt, base, speed, sel_dec;
  logic        nsp_prev, halt_prev, pend, ack, reached, limit, follow;
  logic        hw_clr, mem_we, mem_wa, mem_ra, halt_ramp, pass;
  pps_cmd_t    mem_wd, cur;
  pps_state_t  state;
  function automatic logic [31:0] wrapf(input logic [31:0] p, input logic [31:0] lo,
                                        input logic [31:0] hi);
    logic [31:0] span;
    span = hi - lo + 32'h0000_0001;
    if (hi == lo) wrapf = p;
    else if ($signed(p) > $signed(hi)) wrapf = p - span;
    else if ($signed(p) < $signed(lo)) wrapf = p + span;
    else wrapf = p;
  endfunction : wrapf
  function automatic logic outside(input logic [31:0] v, input logic [31:0] lo,
                                   input logic [31:0] hi);
    outside = ($signed(v) < $signed(lo)) || ($signed(v) > $signed(hi));
  endfunction : outside
  function automatic logic [31:0] absd(input logic [31:0] a, input logic [31:0] b);
    absd = ($signed(a) > $signed(b)) ? a - b : b - a;
  endfunction : absd
  function automatic logic [31:0] umin(input logic [31:0] a, input logic [31:0] b);
    umin = (a < b) ? a : b;
  endfunction : umin
  // AHB-Lite slave, zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_wr   <= 1'b0;
      a_rd   <= 1'b0;
      a_addr <= 8'h00;
    end else if (hready) begin
      a_wr   <= hsel && htrans[1] && hwrite;
      a_rd   <= hsel && htrans[1] && !hwrite;
      a_addr <= haddr[7:0];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= RESP_OKAY[0];
    end
  end
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (haddr[7:0])
      OFF_CTRL:      next_rdata = ctrl;
      OFF_STATUS:    next_rdata = status_w;
      OFF_MODE:      next_rdata = mode;
      OFF_OPTION:    next_rdata = option;
      OFF_PROFILE:   next_rdata = profile;
      OFF_TARGET:    next_rdata = target;
      OFF_LIM_MIN:   next_rdata = lim_min;
      OFF_LIM_MAX:   next_rdata = lim_max;
      OFF_RANGE_MIN: next_rdata = rng_min;
      OFF_RANGE_MAX: next_rdata = rng_max;
      OFF_ACT_POS:   next_rdata = act_pos;
      OFF_DEM_POS:   next_rdata = demand;
      OFF_POS_WIN:   next_rdata = pos_win;
      OFF_WIN_TIME:  next_rdata = win_time;
      OFF_FE_WIN:    next_rdata = fe_win;
      OFF_FE_TIME:   next_rdata = fe_time;
      OFF_TGT_VEL:   next_rdata = tgt_vel;
      OFF_VEL_MIN:   next_rdata = vel_min;
      OFF_VEL_MAX:   next_rdata = vel_max;
      OFF_PROF_VEL:  next_rdata = prof_vel;
      OFF_END_VEL:   next_rdata = end_vel;
      OFF_ACCEL:     next_rdata = acc;
      OFF_DECEL:     next_rdata = dec;
      OFF_QS_DECEL:  next_rdata = qs_dec;
      OFF_MAX_ACC:   next_rdata = max_acc;
      OFF_MAX_DEC:   next_rdata = max_dec;
      OFF_SEL_PAR:   next_rdata = {speed[15:0], sel_dec[15:0]};
      default:       next_rdata = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= RESET_ZERO;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= next_rdata;
    end
  end
  // Parameter registers; controlword self-clear may win over a write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= RESET_ZERO;    mode <= RESET_ZERO;    option <= RESET_ZERO;
      profile <= RESET_ZERO; target <= RESET_ZERO;  lim_min <= RESET_ZERO;
      lim_max <= RESET_ZERO; rng_min <= RESET_ZERO; rng_max <= RESET_ZERO;
      act_pos <= RESET_ZERO; pos_win <= RESET_ZERO; win_time <= RESET_ZERO;
      fe_win <= RESET_ZERO;  fe_time <= RESET_ZERO; tgt_vel <= RESET_ZERO;
      vel_min <= RESET_ZERO; vel_max <= RESET_ZERO; prof_vel <= RESET_ZERO;
      end_vel <= RESET_ZERO; acc <= RESET_ZERO;     dec <= RESET_ZERO;
      qs_dec <= RESET_ZERO;  max_acc <= RESET_ZERO; max_dec <= RESET_ZERO;
    end else begin
      if (a_wr) begin
        case (a_addr)
          OFF_CTRL:      ctrl <= hwdata;
          OFF_MODE:      mode <= hwdata;
          OFF_OPTION:    option <= hwdata;
          OFF_PROFILE:   profile <= hwdata;
          OFF_TARGET:    target <= hwdata;
          OFF_LIM_MIN:   lim_min <= hwdata;
          OFF_LIM_MAX:   lim_max <= hwdata;
          OFF_RANGE_MIN: rng_min <= hwdata;
          OFF_RANGE_MAX: rng_max <= hwdata;
          OFF_ACT_POS:   act_pos <= hwdata;
          OFF_POS_WIN:   pos_win <= hwdata;
          OFF_WIN_TIME:  win_time <= hwdata;
          OFF_FE_WIN:    fe_win <= hwdata;
          OFF_FE_TIME:   fe_time <= hwdata;
          OFF_TGT_VEL:   tgt_vel <= hwdata;
          OFF_VEL_MIN:   vel_min <= hwdata;
          OFF_VEL_MAX:   vel_max <= hwdata;
          OFF_PROF_VEL:  prof_vel <= hwdata;
          OFF_END_VEL:   end_vel <= hwdata;
          OFF_ACCEL:     acc <= hwdata;
          OFF_DECEL:     dec <= hwdata;
          OFF_QS_DECEL:  qs_dec <= hwdata;
          OFF_MAX_ACC:   max_acc <= hwdata;
          OFF_MAX_DEC:   max_dec <= hwdata;
          default:       ;
        endcase
      end
      if (hw_clr) begin
        ctrl[CW_NEW_SP] <= 1'b0;
      end
    end
  end
  // 1 ms control tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt <= RESET_ZERO;
      tick     <= 1'b0;
    end else if (tick_cnt == TICK_LEN - 1) begin
      tick_cnt <= RESET_ZERO;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
      tick     <= 1'b0;
    end
  end
  // Set-point decisions, evaluated once per tick
  logic is_pos, nsp_rise, tgt_ok, take, busy, to_buf;
  logic [31:0] abs_tgt, ref_pos;
  always_comb begin
    is_pos   = (mode[7:0] == MODE_POSITION);
    nsp_rise = ctrl[CW_NEW_SP] && !nsp_prev;
    ref_pos  = option[OPT_REF_LO] ? demand : base;
    abs_tgt  = ctrl[CW_REL] ? wrapf(ref_pos + target, rng_min, rng_max)
                            : wrapf(target, rng_min, rng_max);
    tgt_ok   = !outside(abs_tgt, lim_min, lim_max) ||
               (absd(abs_tgt, demand) == 32'h0000_0000);
    busy     = (state == PPS_MOVE);
    to_buf   = busy && !ctrl[CW_IMMED];
    take     = tick && is_pos && nsp_rise && tgt_ok && !ack &&
               (!busy || ctrl[CW_IMMED] || !pend);
    hw_clr   = take && (option[OPT_CLR_HI] || option[OPT_CLR_LO]);
    mem_wd.target = abs_tgt;
    mem_wd.vel    = prof_vel;
    mem_wd.acc    = acc;
    mem_wd.dec    = dec;
    mem_wd.rel    = ctrl[CW_REL];
    mem_we        = take;
    mem_wa        = to_buf ? !mem_ra : mem_ra;
  end
  pps_param_mem u_mem (
    .hclk    (hclk),
    .hresetn (hresetn),
    .wr_en   (mem_we),
    .wr_addr (mem_wa),
    .wr_data (mem_wd),
    .rd_addr (mem_ra),
    .rd_data (cur)
  );
  // Acknowledge: follows bit 4, or drops once buffer frees
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nsp_prev <= 1'b0;
      ack      <= 1'b0;
    end else if (tick) begin
      nsp_prev <= ctrl[CW_NEW_SP];
      if (take) begin
        ack <= 1'b1;
      end else if (!ctrl[CW_NEW_SP] && !pend) begin
        ack <= 1'b0;
      end
    end
  end
  // Motion sequencer with one pending slot
  logic arrived;
  assign arrived = (demand == cur.target);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state  <= PPS_IDLE;
      pend   <= 1'b0;
      mem_ra <= 1'b0;
      base   <= RESET_ZERO;
    end else if (tick) begin
      if (take && !to_buf) begin
        state  <= PPS_MOVE;
      end else if (take) begin
        pend   <= 1'b1;
      end
      case (state)
        PPS_IDLE:   ;
        PPS_MOVE: begin
          if (arrived && !(take && !to_buf)) begin
            base <= act_pos;
            if (pend || take) begin
              pend   <= 1'b0;
              mem_ra <= !mem_ra;
            end else begin
              state  <= PPS_SETTLE;
            end
          end
        end
        PPS_SETTLE: ;
        default:    state <= PPS_IDLE;
      endcase
    end
  end
  // Demand profile: speed ramp capped, halt and quick stop
  logic [31:0] cap, step_acc;
  always_comb begin
    sel_dec   = ctrl[CW_QSTOP] ? qs_dec : umin(cur.dec, max_dec);
    step_acc  = umin(cur.acc, max_acc);
    halt_ramp = ctrl[CW_HALT];
    pass      = ctrl[CW_CHG_SP] && pend;
    cap       = is_pos ? umin(cur.vel, prof_vel) : tgt_vel;
    if (is_pos && !pass && absd(cur.target, demand) <= speed) cap = end_vel;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      speed     <= RESET_ZERO;
      demand    <= RESET_ZERO;
      halt_prev <= 1'b0;
    end else if (tick) begin
      halt_prev <= halt_ramp;
      if (halt_ramp || ctrl[CW_QSTOP] || (is_pos && state != PPS_MOVE)) begin
        speed <= (speed > sel_dec) ? speed - sel_dec : RESET_ZERO;
      end else if (speed < cap) begin
        speed <= umin(speed + step_acc, cap);
      end else begin
        speed <= (speed - cap > sel_dec) ? speed - sel_dec : cap;
      end
      if (is_pos && state == PPS_MOVE) begin
        if (absd(cur.target, demand) <= speed) demand <= cur.target;
        else if ($signed(cur.target) > $signed(demand)) demand <= demand + speed;
        else demand <= demand - speed;
      end
    end
  end
  // Status: reached, limit, following error
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      win_cnt <= RESET_ZERO;
      fe_cnt  <= RESET_ZERO;
      reached <= 1'b0;
      limit   <= 1'b0;
      follow  <= 1'b0;
    end else if (tick) begin
      if (state == PPS_SETTLE && absd(act_pos, cur.target) <= pos_win) begin
        win_cnt <= win_cnt + 32'h0000_0001;
      end else begin
        win_cnt <= RESET_ZERO;
      end
      reached <= (state == PPS_SETTLE) && (win_cnt >= win_time);
      limit   <= is_pos ? outside(demand, lim_min, lim_max)
                        : outside(tgt_vel, vel_min, vel_max);
      if (ctrl[CW_CLOSED] && absd(demand, act_pos) > fe_win) begin
        fe_cnt <= fe_cnt + 32'h0000_0001;
      end else begin
        fe_cnt <= RESET_ZERO;
      end
      follow  <= ctrl[CW_CLOSED] && (fe_cnt > fe_time);
    end
  end
  always_comb begin
    status_w = 32'h0000_0000;
    status_w[SW_REACHED]  = reached;
    status_w[SW_LIMIT]    = limit;
    status_w[SW_ACK]      = ack;
    status_w[SW_FOLLOW]   = follow;
    status_w[SW_BUF_FULL] = pend;
    status_w[SW_JERK]     = (profile[7:0] == PROFILE_JERK);
    status_w[SW_PASS]     = pass;
    status_w[SW_QS_RAMP]  = ctrl[CW_QSTOP];
    status_w[SW_HALTED]   = halt_prev && (speed == RESET_ZERO);
  end
  a_ack_no_pend: assert property (@(posedge hclk) disable iff (!hresetn)
    (tick && ack) |-> !take) else $error("took command while ack set");
  a_take_ack: assert property (@(posedge hclk) disable iff (!hresetn)
    take |=> ack) else $error("ack not raised");
  a_reached_ok: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(reached) |-> $past(state) == PPS_SETTLE) else $error("reached without settle");
  a_limit_pos: assert property (@(posedge hclk) disable iff (!hresetn)
    (tick && is_pos && outside(demand, lim_min, lim_max)) |=> limit)
    else $error("limit bit missing");
  a_follow_clr: assert property (@(posedge hclk) disable iff (!hresetn)
    (tick && !ctrl[CW_CLOSED]) |=> !follow) else $error("following error open loop");
  a_tick_gap: assert property (@(posedge hclk) disable iff (!hresetn)
    tick |=> !tick) else $error("tick too close");
  a_no_unreach: assert property (@(posedge hclk) disable iff (!hresetn)
    (tick && !ack && outside(abs_tgt, lim_min, lim_max) && abs_tgt != demand) |=> !ack)
    else $error("unreachable target acknowledged");
  a_selfclr: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && option[OPT_CLR_LO]) |=> !ctrl[CW_NEW_SP]) else $error("no self clear");
endmodule : pps_setpoint_ctrl

// file: tb/pps_bus_master.sv
`timescale 1ns/1ps
// Single-transfer bus master standing in for the host
module pps_bus_master (
  input  wire logic        hclk,   // Clock
  input  wire logic        hready, // Bus ready
  input  wire logic [31:0] hrdata, // Read data
  output logic             hsel,   // Slave select
  output logic [31:0]      haddr,  // Address
  output logic [1:0]       htrans, // Transfer type
  output logic             hwrite, // Write
  output logic [2:0]       hsize,  // Size
  output logic [31:0]      hwdata  // Write data
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end
  // Address phase held until ready, then data phase held until ready
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hwdata <= ~hwdata;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask : xfer
endmodule : pps_bus_master

// file: tb/testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module testbench;
  import pps_pkg::*;
  localparam int unsigned TL = 20;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        tick;
  logic [31:0] demand;
  logic [31:0] s;
  int          err_total;
  int          samples_checked;

  pps_bus_master m (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  pps_setpoint_ctrl #(.TICK_LEN(TL)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .tick(tick),
    .demand(demand));

  always #5 hclk = ~hclk;

  task automatic wr(input logic [7:0] o, input logic [31:0] d);
    logic [31:0] q;
    m.xfer(1'b1, {24'h0, o}, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] o, output logic [31:0] q);
    m.xfer(1'b0, {24'h0, o}, 32'h0000_0000, q);
  endtask : rd
  // Control decisions land only on ticks
  task automatic ticks(input int n);
    repeat (n) begin
      do @(negedge hclk); while (tick !== 1'b1);
    end
  endtask : ticks
  task automatic chk_st(input int b, input logic e, input string n);
    rd(OFF_STATUS, s);
    `CHK(n, e, s[b])
  endtask : chk_st
  task automatic reach(input logic [31:0] t);
    int n;
    n = 0;
    while (demand !== t && n < 20000) begin
      @(negedge hclk);
      n++;
    end
    `CHK("demand", t, demand)
  endtask : reach
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  initial begin
    repeat (40000) @(posedge hclk);
    err_total++;
    $display("ERROR watchdog expected done seen hang");
    results();
  end

  initial begin
    int n;
    hclk = 1'b0;
    hresetn = 1'b0;
    err_total = 0;
    samples_checked = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    ticks(1);
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (tick !== 1'b1);
    `CHK("tick period", TL, n)
    rd(OFF_STATUS, s);
    `CHK("status reset", RESET_ZERO, s)
    `CHK("readyout", 1'b1, hreadyout)
    `CHK("resp", 1'b0, hresp)
    wr(8'h80, 32'hFFFF_FFFF);
    rd(8'h80, s);
    `CHK("unmapped", 32'h0000_0000, s)
    wr(OFF_MODE, {24'h0, MODE_POSITION});
    wr(OFF_LIM_MAX, 32'h0000_1000);
    wr(OFF_RANGE_MAX, 32'h0001_0000);
    wr(OFF_PROF_VEL, 32'h0000_0004);
    wr(OFF_ACCEL, 32'h0000_1000);
    wr(OFF_DECEL, 32'h0000_1000);
    wr(OFF_MAX_ACC, 32'h0000_1000);
    wr(OFF_MAX_DEC, 32'h0000_1000);
    wr(OFF_POS_WIN, 32'h0000_0002);
    wr(OFF_WIN_TIME, 32'h0000_0002);
    wr(OFF_FE_WIN, 32'h0000_1000);
    wr(OFF_FE_TIME, 32'h0000_0100);
    wr(OFF_ACT_POS, 32'h0000_0040);
    wr(OFF_PROFILE, {24'h0, PROFILE_JERK});
    ticks(2);
    chk_st(SW_JERK, 1'b1, "jerk mode");
    wr(OFF_PROFILE, 32'h0000_0000);
    ticks(2);
    chk_st(SW_JERK, 1'b0, "jerk mode");
    // Target beyond the limits is refused
    wr(OFF_TARGET, 32'h0000_5000);
    wr(OFF_CTRL, 32'h0000_0010);
    ticks(3);
    chk_st(SW_ACK, 1'b0, "ack bad target");
    wr(OFF_CTRL, 32'h0000_0000);
    ticks(2);
    wr(OFF_TARGET, 32'h0000_0040);
    wr(OFF_CTRL, 32'h0000_0010);
    ticks(3);
    chk_st(SW_ACK, 1'b1, "ack set");
    wr(OFF_CTRL, 32'h0000_0000);
    ticks(3);
    chk_st(SW_ACK, 1'b0, "ack clear");
    reach(32'h0000_0040);
    ticks(5);
    chk_st(SW_REACHED, 1'b1, "reached");
    wr(OFF_LIM_MIN, 32'h0000_0100);
    wr(OFF_LIM_MAX, 32'h0000_0200);
    ticks(2);
    chk_st(SW_LIMIT, 1'b1, "pos limit");
    wr(OFF_LIM_MIN, 32'h0000_0000);
    wr(OFF_LIM_MAX, 32'h0000_1000);
    ticks(2);
    chk_st(SW_LIMIT, 1'b0, "pos limit");
    wr(OFF_OPTION, 32'h0000_0010);
    wr(OFF_TARGET, 32'h0000_0080);
    wr(OFF_CTRL, 32'h0000_0010);
    ticks(3);
    rd(OFF_CTRL, s);
    `CHK("self clear", 1'b0, s[CW_NEW_SP])
    wr(OFF_OPTION, 32'h0000_0000);
    reach(32'h0000_0080);
    // Slow move, then one buffered and one surplus command
    wr(OFF_PROF_VEL, 32'h0000_0001);
    wr(OFF_TARGET, 32'h0000_0400);
    wr(OFF_CTRL, 32'h0000_0010);
    ticks(3);
    chk_st(SW_ACK, 1'b1, "ack move");
    wr(OFF_CTRL, 32'h0000_0000);
    ticks(3);
    chk_st(SW_ACK, 1'b0, "ack room");
    wr(OFF_TARGET, 32'h0000_0100);
    wr(OFF_CTRL, 32'h0000_0010);
    ticks(3);
    chk_st(SW_BUF_FULL, 1'b1, "buffer full");
    wr(OFF_CTRL, 32'h0000_0000);
    ticks(3);
    chk_st(SW_ACK, 1'b1, "ack pending");
    wr(OFF_TARGET, 32'h0000_0300);
    wr(OFF_CTRL, 32'h0000_0010);
    ticks(3);
    chk_st(SW_BUF_FULL, 1'b1, "buffer kept");
    chk_st(SW_ACK, 1'b1, "ack held");
    wr(OFF_MODE, {24'h0, MODE_VELOCITY});
    wr(OFF_VEL_MAX, 32'h0000_0100);
    wr(OFF_TGT_VEL, 32'h0000_0500);
    ticks(3);
    chk_st(SW_LIMIT, 1'b1, "vel limit");
    wr(OFF_TGT_VEL, 32'h0000_0050);
    ticks(3);
    chk_st(SW_LIMIT, 1'b0, "vel limit");
    wr(OFF_CTRL, 32'h0000_0100);
    ticks(3);
    chk_st(SW_HALTED, 1'b1, "halted");
    wr(OFF_QS_DECEL, 32'h0000_0003);
    wr(OFF_CTRL, 32'h0000_0000);
    ticks(3);
    rd(OFF_SEL_PAR, s);
    `CHK("run speed", 32'h0050_1000, s)
    wr(OFF_CTRL, 32'h0000_0004);
    ticks(2);
    rd(OFF_SEL_PAR, s);
    `CHK("qs decel", 16'h0003, s[15:0])
    wr(OFF_FE_WIN, 32'h0000_0000);
    wr(OFF_FE_TIME, 32'h0000_0001);
    wr(OFF_CTRL, 32'h0000_0400);
    ticks(4);
    chk_st(SW_FOLLOW, 1'b1, "follow err");
    wr(OFF_CTRL, 32'h0000_0000);
    ticks(2);
    chk_st(SW_FOLLOW, 1'b0, "follow err");
    results();
  end
endmodule : testbench
